/* File: rtl/ssp_port_map.vh */
`ifndef SSP_PORT_MAP_VH
`define SSP_PORT_MAP_VH

// register byte offsets on the ahb-lite slave
`define SSP_OFS_CTRL 8'h00
`define SSP_OFS_STATUS 8'h04
`define SSP_OFS_ACC_CNT 8'h08
`define SSP_OFS_LAST_ADDR 8'h0c

// control register fields and reset value
`define SSP_CTRL_EN_BIT 0
`define SSP_CTRL_RST 32'h0000_0001

// status register fields
`define SSP_STAT_SEL_BIT 0
`define SSP_STAT_ACT_BIT 1
`define SSP_STAT_WR_BIT 2
`define SSP_STAT_SUSP_BIT 3

// data word layout: four lanes of eight bits plus one parity bit each
`define SSP_LANES 4
`define SSP_LANE_W 8
`define SSP_WORD_W 36

// ahb-lite encodings
`define SSP_HTRANS_NONSEQ 2'h2
`define SSP_HTRANS_SEQ 2'h3
`define SSP_HSIZE_WORD 3'h2

`endif

/* File: rtl/ssp_port.v */
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "ssp_port_map.vh"

module ssp_port #(
  parameter ADDR_W = 21
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // memory control port from the host controller
  input wire [ADDR_W-1:0] addr_i,
  input wire byte_wr_sel_lane0_n_i,
  input wire byte_wr_sel_lane1_n_i,
  input wire byte_wr_sel_lane2_n_i,
  input wire byte_wr_sel_lane3_n_i,
  input wire wr_strobe_n_i,
  input wire advance_or_load_i,
  input wire clock_gate_n_i,
  input wire chip_sel_first_n_i,
  input wire chip_sel_second_i,
  input wire chip_sel_third_n_i,
  // access request toward the memory array
  output reg acc_stb_o,
  output reg acc_wr_o,
  output reg [ADDR_W-1:0] acc_addr_o,
  output reg [`SSP_WORD_W-1:0] acc_wr_mask_o,
  output reg selected_o,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o
);

  // expand per-lane enables to a full word mask, parity bits on top
  function [`SSP_WORD_W-1:0] ssp_lane_mask;
    input [`SSP_LANES-1:0] lanes;
    integer i;
    begin
      ssp_lane_mask = {`SSP_WORD_W{1'b0}};
      for (i = 0; i < `SSP_LANES; i = i + 1) begin
        ssp_lane_mask[i*`SSP_LANE_W +: `SSP_LANE_W] = {`SSP_LANE_W{lanes[i]}};
        ssp_lane_mask[`SSP_LANES*`SSP_LANE_W + i] = lanes[i];
      end
    end
  endfunction

  // what one edge asks of the port; only taken edges do anything
  localparam OP_HOLD = 3'h0;
  localparam OP_DESEL = 3'h1;
  localparam OP_LOAD = 3'h2;
  localparam OP_STEP = 3'h3;
  localparam OP_IDLE = 3'h4;

  // classify an edge; an advance only steps a burst that is running
  function [2:0] ssp_edge_op;
    input take;
    input sel;
    input adv;
    input run;
    begin
      if (!take) begin
        ssp_edge_op = OP_HOLD;
      end else if (!sel) begin
        ssp_edge_op = OP_DESEL;
      end else if (!adv) begin
        ssp_edge_op = OP_LOAD;
      end else if (run) begin
        ssp_edge_op = OP_STEP;
      end else begin
        ssp_edge_op = OP_IDLE;
      end
    end
  endfunction

  // the three selects must agree; any other mix deselects
  function ssp_sel_match;
    input first_n;
    input second;
    input third_n;
    begin
      ssp_sel_match = ~first_n & second & ~third_n;
    end
  endfunction

  // linear burst order: the low two bits count and wrap
  function [1:0] ssp_burst_next;
    input [1:0] cnt;
    begin
      ssp_burst_next = cnt + 2'h1;
    end
  endfunction

  // ahb register offsets that accept a write
  function ssp_wr_hit;
    input [7:0] ofs;
    begin
      ssp_wr_hit = (ofs == `SSP_OFS_CTRL);
    end
  endfunction

  // internal state
  reg [31:0] ctrl_ff;
  reg [ADDR_W-1:0] base_addr_ff;
  reg [1:0] burst_cnt_ff;
  reg active_ff;
  reg wr_mode_ff;
  reg susp_ff;
  reg [31:0] acc_cnt_ff;
  reg [31:0] nxt_acc_cnt;
  reg nxt_acc_stb;
  reg nxt_acc_wr;
  reg [ADDR_W-1:0] nxt_acc_addr;
  reg [`SSP_WORD_W-1:0] nxt_acc_wr_mask;
  reg nxt_selected;
  reg [ADDR_W-1:0] nxt_base_addr;
  reg [1:0] nxt_burst_cnt;
  reg nxt_active;
  reg nxt_wr_mode;

  wire port_en = ctrl_ff[`SSP_CTRL_EN_BIT];
  wire take_edge = ~clock_gate_n_i;
  // a disabled port looks deselected to the host
  wire sel_now = ssp_sel_match(chip_sel_first_n_i, chip_sel_second_i,
                               chip_sel_third_n_i) & port_en;
  wire [`SSP_LANES-1:0] lane_en_n = {byte_wr_sel_lane3_n_i,
                                     byte_wr_sel_lane2_n_i,
                                     byte_wr_sel_lane1_n_i,
                                     byte_wr_sel_lane0_n_i};
  wire [1:0] burst_inc = ssp_burst_next(burst_cnt_ff);
  // lane mask from the selects presented at this edge
  wire [`SSP_WORD_W-1:0] lane_mask = ssp_lane_mask(~lane_en_n);
  // byte selects count only on a write; reads carry an empty mask
  wire [`SSP_WORD_W-1:0] load_mask = wr_strobe_n_i ? {`SSP_WORD_W{1'b0}} :
                                     lane_mask;
  wire [`SSP_WORD_W-1:0] step_mask = wr_mode_ff ? lane_mask :
                                     {`SSP_WORD_W{1'b0}};
  // next beat keeps the upper address and wraps in the low two bits
  wire [ADDR_W-1:0] step_addr = {base_addr_ff[ADDR_W-1:2], burst_inc};
  wire [2:0] edge_op = ssp_edge_op(take_edge, sel_now, advance_or_load_i,
                                   active_ff);

  // access decode for one edge; held values are the default
  always @* begin
    nxt_acc_stb = 1'b0;
    nxt_acc_wr = acc_wr_o;
    nxt_acc_addr = acc_addr_o;
    nxt_acc_wr_mask = acc_wr_mask_o;
    nxt_selected = selected_o;
    nxt_base_addr = base_addr_ff;
    nxt_burst_cnt = burst_cnt_ff;
    nxt_active = active_ff;
    nxt_wr_mode = wr_mode_ff;
    nxt_acc_cnt = acc_cnt_ff;
    case (edge_op)
      OP_DESEL: begin
        // deselect drops the burst; strobe and byte selects ignored
        nxt_selected = 1'b0;
        nxt_active = 1'b0;
        nxt_acc_wr_mask = {`SSP_WORD_W{1'b0}};
      end
      OP_LOAD: begin
        // new access from the presented address
        nxt_selected = 1'b1;
        nxt_base_addr = addr_i;
        nxt_burst_cnt = addr_i[1:0];
        nxt_active = 1'b1;
        nxt_wr_mode = ~wr_strobe_n_i;
        nxt_acc_stb = 1'b1;
        nxt_acc_wr = ~wr_strobe_n_i;
        nxt_acc_addr = addr_i;
        nxt_acc_wr_mask = load_mask;
        nxt_acc_cnt = acc_cnt_ff + 32'h1;
      end
      OP_STEP: begin
        // burst step; read or write kind was fixed at load
        nxt_selected = 1'b1;
        nxt_burst_cnt = burst_inc;
        nxt_acc_stb = 1'b1;
        nxt_acc_wr = wr_mode_ff;
        nxt_acc_addr = step_addr;
        nxt_acc_wr_mask = step_mask;
        nxt_acc_cnt = acc_cnt_ff + 32'h1;
      end
      OP_IDLE: begin
        // advance with no loaded address starts nothing
        nxt_selected = 1'b1;
        nxt_acc_wr_mask = {`SSP_WORD_W{1'b0}};
      end
      OP_HOLD: begin
        // gated edges leave everything held, selection included
        nxt_acc_stb = 1'b0;
      end
      default: begin
        nxt_acc_stb = 1'b0;
      end
    endcase
  end

  // access request outputs; a gated edge reloads the held values
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_stb_o <= 1'b0;
      acc_wr_o <= 1'b0;
      acc_addr_o <= {ADDR_W{1'b0}};
      acc_wr_mask_o <= {`SSP_WORD_W{1'b0}};
      selected_o <= 1'b0;
    end else begin
      acc_stb_o <= nxt_acc_stb;
      acc_wr_o <= nxt_acc_wr;
      acc_addr_o <= nxt_acc_addr;
      acc_wr_mask_o <= nxt_acc_wr_mask;
      selected_o <= nxt_selected;
    end
  end

  // burst tracking and the access counter
  always @(posedge clk_i) begin
    if (rst_i) begin
      base_addr_ff <= {ADDR_W{1'b0}};
      burst_cnt_ff <= 2'h0;
      active_ff <= 1'b0;
      wr_mode_ff <= 1'b0;
      acc_cnt_ff <= 32'h0;
    end else begin
      base_addr_ff <= nxt_base_addr;
      burst_cnt_ff <= nxt_burst_cnt;
      active_ff <= nxt_active;
      wr_mode_ff <= nxt_wr_mode;
      acc_cnt_ff <= nxt_acc_cnt;
    end
  end

  // gate level of the last edge, kept for status only
  always @(posedge clk_i) begin
    if (rst_i) begin
      susp_ff <= 1'b0;
    end else begin
      susp_ff <= clock_gate_n_i;
    end
  end

  // ahb-lite slave: zero wait states, always okay
  reg dphase_wr_ff;
  reg [7:0] dphase_ofs_ff;
  reg [31:0] rd_val;
  wire ahb_take = hsel_i & hready_i & htrans_i[1];
  wire [7:0] ahb_ofs = haddr_i[7:0];

  // read mux sampled in the address phase, so data stands in the data phase
  always @* begin
    case (ahb_ofs)
      `SSP_OFS_CTRL: rd_val = ctrl_ff;
      `SSP_OFS_STATUS: rd_val = {28'h0, susp_ff, wr_mode_ff, active_ff,
                                 selected_o};
      `SSP_OFS_ACC_CNT: rd_val = acc_cnt_ff;
      `SSP_OFS_LAST_ADDR: rd_val = {{(32-ADDR_W){1'b0}}, acc_addr_o};
      default: rd_val = 32'h0;
    endcase
  end

  // address phase capture; no wait states are ever inserted
  always @(posedge clk_i) begin
    if (rst_i) begin
      dphase_wr_ff <= 1'b0;
      dphase_ofs_ff <= 8'h00;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      dphase_wr_ff <= ahb_take & hwrite_i;
      dphase_ofs_ff <= ahb_ofs;
      // loaded here so the word stands through the data phase
      if (ahb_take && !hwrite_i) begin
        hrdata_o <= rd_val;
      end
    end
  end

  // control register; writes to other offsets are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `SSP_CTRL_RST;
    end else if (dphase_wr_ff && ssp_wr_hit(dphase_ofs_ff)) begin
      ctrl_ff <= {31'h0, hwdata_i[`SSP_CTRL_EN_BIT]};
    end
  end

endmodule // ssp_port

/* File: verification/ssp_host.sv */
`timescale 1ns/1ps
// host controller model: drives the control pins after each edge
module ssp_host (
  input wire clk_i,
  output reg [30:0] pins_o
);
  // start deselected with the clock gated, so no edge is taken
  initial pins_o = {31{1'b1}};
  // one bus cycle; a low write strobe begins a write
  task cyc(input [30:0] v);
    begin
      @(posedge clk_i);
      pins_o <= v;
    end
  endtask
endmodule // ssp_host

/* File: verification/ssp_port_chk.sv */
`timescale 1ns/1ps
module ssp_port_chk #(
  parameter ADDR_W = 21
) (
  // clock, reset and control pins
  input wire clk_i, rst_i, wr_strobe_n_i, advance_or_load_i,
  input wire clock_gate_n_i, chip_sel_first_n_i, chip_sel_second_i,
  input wire chip_sel_third_n_i, byte_wr_sel_lane0_n_i,
  input wire byte_wr_sel_lane1_n_i, byte_wr_sel_lane2_n_i,
  input wire byte_wr_sel_lane3_n_i,
  input wire [ADDR_W-1:0] addr_i,
  // access request
  input wire acc_stb_o, acc_wr_o, selected_o,
  input wire [ADDR_W-1:0] acc_addr_o,
  input wire [35:0] acc_wr_mask_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // taken edge, select decode and expected lane mask
  wire tk = !clock_gate_n_i;
  wire sl = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
  wire [3:0] b = ~{byte_wr_sel_lane3_n_i, byte_wr_sel_lane2_n_i,
    byte_wr_sel_lane1_n_i, byte_wr_sel_lane0_n_i};
  wire [35:0] m = {b, {8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  property p_gate;
    !tk |=> !acc_stb_o && $stable(acc_addr_o) && $stable(acc_wr_o)
      && $stable(acc_wr_mask_o);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated edge moved");
  property p_hold;
    !tk |=> $stable(selected_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("gate deselected");
  property p_load;
    tk && sl && !advance_or_load_i |=> !selected_o || (acc_stb_o &&
      acc_addr_o == $past(addr_i) && acc_wr_o == !$past(wr_strobe_n_i));
  endproperty
  a_load: assert property (p_load)
    else $error("bad load");
  property p_desel;
    tk && !sl |=> !selected_o && !acc_stb_o && acc_wr_mask_o == 36'h0;
  endproperty
  a_desel: assert property (p_desel)
    else $error("bad deselect");
  property p_mask;
    acc_stb_o && acc_wr_o |-> acc_wr_mask_o == $past(m);
  endproperty
  a_mask: assert property (p_mask)
    else $error("bad lane mask");
  property p_rd;
    acc_stb_o && !acc_wr_o |-> acc_wr_mask_o == 36'h0;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read with mask");
  property p_adv;
    acc_stb_o && tk && sl && advance_or_load_i |=> acc_stb_o &&
      acc_addr_o[1:0] == $past(acc_addr_o[1:0]) + 2'h1 &&
      acc_addr_o[ADDR_W-1:2] == $past(acc_addr_o[ADDR_W-1:2]);
  endproperty
  a_adv: assert property (p_adv)
    else $error("bad advance");
  property p_adv0;
    !selected_o && tk && advance_or_load_i |=> !acc_stb_o;
  endproperty
  a_adv0: assert property (p_adv0)
    else $error("advance unloaded");
  // main scenarios
  c_wr: cover property (acc_stb_o && acc_wr_o);
  c_adv: cover property (tk && sl && advance_or_load_i ##1 acc_stb_o);
  c_gate: cover property (acc_stb_o ##1 !tk);
endmodule // ssp_port_chk

/* File: verification/ssp_port_tb.sv */
`timescale 1ns/1ps
`include "ssp_port_map.vh"
module ssp_port_tb;
  reg clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, en = 1'b1;
  reg act = 1'b0, bwr = 1'b0, sel_l = 1'b0;
  reg [31:0] rnd;
  reg [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
  reg [1:0] htrans_i = 2'h0;
  reg [20:0] ba = 21'h0;
  reg [30:0] v;
  reg [57:0] q[$];
  integer n_fail = 0, cmp_count = 0, seed = 44, cyc_n = 0, cnt = 0, i;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, acc_stb_o, acc_wr_o, selected_o;
  wire [20:0] addr_i, acc_addr_o;
  wire [35:0] acc_wr_mask_o;
  wire [30:0] pins_w;
  wire wr_strobe_n_i, advance_or_load_i, clock_gate_n_i, chip_sel_first_n_i;
  wire chip_sel_second_i, chip_sel_third_n_i, byte_wr_sel_lane0_n_i;
  wire byte_wr_sel_lane1_n_i, byte_wr_sel_lane2_n_i, byte_wr_sel_lane3_n_i;
  // host pins: address, selects 3..0, strobe, advance, gate, chip selects
  assign {addr_i, byte_wr_sel_lane3_n_i, byte_wr_sel_lane2_n_i,
    byte_wr_sel_lane1_n_i, byte_wr_sel_lane0_n_i, wr_strobe_n_i,
    advance_or_load_i, clock_gate_n_i, chip_sel_first_n_i,
    chip_sel_second_i, chip_sel_third_n_i} = pins_w;
  ssp_host u_host (.clk_i, .pins_o(pins_w));
  ssp_port DUT (.clk_i, .rst_i, .addr_i, .byte_wr_sel_lane0_n_i,
    .byte_wr_sel_lane1_n_i, .byte_wr_sel_lane2_n_i, .byte_wr_sel_lane3_n_i,
    .wr_strobe_n_i, .advance_or_load_i, .clock_gate_n_i, .chip_sel_first_n_i,
    .chip_sel_second_i, .chip_sel_third_n_i, .acc_stb_o, .acc_wr_o,
    .acc_addr_o, .acc_wr_mask_o, .selected_o, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(`SSP_HSIZE_WORD), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o);
  initial forever #5 clk_i = ~clk_i;
  task chk(input [63:0] s, input [63:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task close_out;
    begin
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // single ahb transfer; on a read d is the expected word
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      {hsel_i, haddr_i, htrans_i, hwrite_i} <= {1'b1, 24'h0, a, 2'h2, w};
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      {hsel_i, htrans_i, hwdata_i} <= {3'h0, d};
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      if (!w) chk({hresp_o, hrdata_o}, {1'b0, d});
    end
  endtask
  // drive one host cycle and note the access it should start
  task step(input [30:0] x);
    begin
      u_host.cyc(x);
      if (!x[3]) sel_l = x[2:0] == 3'b010 && en;
      if (!x[3] && x[2:0] == 3'b010 && en && (!x[4] || act)) begin
        if (!x[4]) {act, bwr, ba} = {1'b1, !x[5], x[30:10]};
        else ba[1:0] = ba[1:0] + 2'h1;
        q.push_back({bwr, ba, bwr ? {~x[9:6], {8{~x[9]}}, {8{~x[8]}},
          {8{~x[7]}}, {8{~x[6]}}} : 36'h0});
        cnt = cnt + 1;
      end else if (!x[3]) act = 1'b0;
    end
  endtask
  // each started access is matched against the oldest note
  always @(posedge clk_i)
    if (acc_stb_o === 1'b1)
      chk({acc_wr_o, acc_addr_o, acc_wr_mask_o}, q.pop_front());
  // hang guard, well above the fewer than 700 cycles needed
  always @(posedge clk_i) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 5000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    ahb(1'b0, `SSP_OFS_CTRL, 32'h1);
    ahb(1'b0, 8'h10, 32'h0);
    for (i = 0; i < 600; i = i + 1) begin
      // gated pins keep register traffic from racing the port
      if (i == 300 || i == 330) begin
        step({31{1'b1}});
        ahb(1'b1, `SSP_OFS_CTRL, {31'h0, !en});
        en = !en;
      end
      rnd = $random(seed);
      v = rnd[30:0];
      if (v[12]) v[2:0] = 3'b010;
      v[3] = v[3] & v[11];
      step(v);
    end
    step({31{1'b1}});
    ahb(1'b0, `SSP_OFS_STATUS, {28'h0, 1'b1, bwr, act, sel_l});
    ahb(1'b0, `SSP_OFS_ACC_CNT, cnt);
    ahb(1'b0, `SSP_OFS_LAST_ADDR, {11'h0, ba});
    chk(q.size(), 64'h0);
    close_out;
  end
endmodule // ssp_port_tb
bind ssp_port ssp_port_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i, .rst_i,
  .wr_strobe_n_i, .advance_or_load_i, .clock_gate_n_i, .chip_sel_first_n_i,
  .chip_sel_second_i, .chip_sel_third_n_i, .byte_wr_sel_lane0_n_i,
  .byte_wr_sel_lane1_n_i, .byte_wr_sel_lane2_n_i, .byte_wr_sel_lane3_n_i,
  .addr_i, .acc_stb_o, .acc_wr_o, .selected_o, .acc_addr_o, .acc_wr_mask_o);
